/* File: hdl/busy_timer.sv */
// Down counter that holds busy for a loaded number of cycles
`timescale 1ns/10ps
`default_nettype none
module busy_timer (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic load, // Start pulse
  input wire logic [7:0] count, // Cycles to stay busy
  output logic busy // High while counting
);
  logic [7:0] cnt_reg;

  // Count down to zero once loaded
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 8'h00;
    else if (load)
      cnt_reg <= count;
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
  end

  assign busy = (cnt_reg != 8'h00);
endmodule
`default_nettype wire

/* File: hdl/flash_erase_program_control.sv */
// Flash erase and program control: mapping, arming, command decode, toggle status
// Behaviour
// - Key 0xd4 applies RAM map and vector move.
// - Arm mode and area apply on 0xd5 key.
// - Disarm mode blocks commands, restores default area; here disarm loads the staged area field instead.
// - Busy reads toggle; stable reads mean done.
// - Cleared bits plus 0xd4 restore flash map.
// - Vectors left in flash give bad fetch.
// - Command sequence uses 0xf555 and 0xfaaa unlocks.
// - Nonmaskable interrupt waits done then resets.
// - Writing 0x10 to reset control resets clocks.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_erase_program_control (
  input wire logic sys_clk, // System clock, 25 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [15:0] regAddr, // Register address
  input wire logic [7:0] regWdata, // Register write data
  input wire logic regWr, // Register write strobe
  input wire logic regRd, // Register read strobe
  output logic [7:0] regRdata, // Register read data, next cycle
  input wire logic [15:0] memAddr, // CPU flash bus address
  input wire logic [7:0] memWdata, // CPU flash bus write data
  input wire logic memWr, // CPU flash write strobe
  input wire logic memRd, // CPU flash read strobe
  input wire logic [7:0] arrayRdata, // Flash array data at memAddr
  output logic [7:0] memRdata, // Flash read data, next cycle
  output logic arrayErase, // Sector erase pulse to array
  output logic arrayProgram, // Byte program pulse to array
  output logic [15:0] arrayAddr, // Target address to array
  output logic [7:0] arrayData, // Program data to array
  input wire logic nmiEvent, // Nonmaskable interrupt taken
  output logic ramCodeMap, // RAM mapped into code space
  output logic vecRelocate, // Vectors fetched from RAM
  output logic [1:0] flashArea, // Applied area select
  output logic romBankSelect, // Applied ROM select
  output logic bootRomArea, // Boot ROM mapped in
  output logic sysClkReset, // System clock reset pulse
  output logic irq // Level interrupt
);
  flash_ctl_pkg::seq_state_t seq_reg, seq_next;
  flash_ctl_pkg::bus_req_t req;
  flash_ctl_pkg::map_state_t map_reg;
  logic [7:0] mapCtl_reg;
  logic [7:0] primary_reg;
  logic armed_reg;
  logic [1:0] area_reg;
  logic rom_bank_select_reg;
  logic boot_reg;
  logic isErase_reg;
  logic toggle_reg;
  logic nmiPending_reg;
  logic rstPulse_reg;
  logic [7:0] regRdata_reg;
  logic [7:0] memRdata_reg;
  logic [7:0] spacing_reg;
  logic [2:0] irqMask_reg;
  logic [2:0] irqStat;
  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic busy;
  logic startOp;
  logic cmdAccept;
  logic rejectEvt;
  logic doneEvt;
  logic busyDly_reg;
  logic tooSoon;
  logic wrMapCtl, wrMapKey, wrRstCtl, wrPrimary, wrConfirm, wrIrqStat, wrIrqMask;

  assign req = '{wr: memWr, rd: memRd, addr: memAddr, data: memWdata};

  // Register write decode
  always_comb
  begin
    wrMapCtl = 1'b0;
    wrMapKey = 1'b0;
    wrRstCtl = 1'b0;
    wrPrimary = 1'b0;
    wrConfirm = 1'b0;
    wrIrqStat = 1'b0;
    wrIrqMask = 1'b0;
    if (regWr)
    begin
      if (regAddr == `ADDR_SYS_MAP_CONTROL)
        wrMapCtl = 1'b1;
      else if (regAddr == `ADDR_SYS_MAP_KEY)
        wrMapKey = 1'b1;
      else if (regAddr == `ADDR_SYS_RESET_CONTROL)
        wrRstCtl = 1'b1;
      else if (regAddr == `ADDR_FLASH_CTRL_PRIMARY)
        wrPrimary = 1'b1;
      else if (regAddr == `ADDR_FLASH_CTRL_CONFIRM)
        wrConfirm = 1'b1;
      else if (regAddr == `ADDR_IRQ_STATUS)
        wrIrqStat = 1'b1;
      else if (regAddr == `ADDR_IRQ_MASK)
        wrIrqMask = 1'b1;
    end
  end

  // Map control staging; nothing moves until the key arrives
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mapCtl_reg <= `RST_MAP;
    else if (wrMapCtl)
      mapCtl_reg <= regWdata;
  end

  // Key 0xd4 applies map bits, both for entering and leaving RAM
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      map_reg <= '{ramCode: 1'b0, vecRam: 1'b0};
    else if (wrMapKey && regWdata == `KEY_MAP)
      map_reg <= '{ramCode: mapCtl_reg[`MAP_RAM_BIT], vecRam: mapCtl_reg[`MAP_VEC_BIT]};
  end

  // Vector fetch source follows the applied bit; flash stays unsafe while busy
  assign ramCodeMap = map_reg.ramCode;
  assign vecRelocate = map_reg.vecRam;

  // Primary flash control staging
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      primary_reg <= `RST_PRIMARY;
    else if (wrPrimary)
      primary_reg <= regWdata;
  end

  // Confirm key applies the staged primary settings
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_reg <= 1'b0;
      area_reg <= `AREA_DEFAULT;
      rom_bank_select_reg <= 1'b0;
      boot_reg <= 1'b0;
    end
    else if (wrConfirm && regWdata == `KEY_CONFIRM)
    begin
      boot_reg <= primary_reg[`PRI_BOOT_BIT];
      if (primary_reg[`PRI_MODE_HI:`PRI_MODE_LO] == `MODE_ARM)
      begin
        armed_reg <= 1'b1;
        area_reg <= primary_reg[`PRI_AREA_HI:`PRI_AREA_LO];
        rom_bank_select_reg <= primary_reg[`PRI_ROM_BANK_SELECT_BIT];
      end
      else if (primary_reg[`PRI_MODE_HI:`PRI_MODE_LO] == `MODE_DISARM)
      begin
        armed_reg <= 1'b0;
        area_reg <= primary_reg[`PRI_AREA_HI:`PRI_AREA_LO];
        rom_bank_select_reg <= 1'b0;
      end
    end
  end

  assign flashArea = area_reg;
  assign romBankSelect = rom_bank_select_reg;
  assign bootRomArea = boot_reg;

  // Spacing counter; too-close command writes abort the sequence
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      spacing_reg <= 8'h00;
    else if (req.wr)
      spacing_reg <= 8'(`MIN_CMD_CYCLES - 1);
    else if (spacing_reg != 8'h00)
      spacing_reg <= spacing_reg - 8'h01;
  end

  assign tooSoon = (spacing_reg != 8'h00) && (seq_reg != flash_ctl_pkg::SEQ_IDLE);

  // Command sequence decode
  always_comb
  begin
    seq_next = seq_reg;
    startOp = 1'b0;
    cmdAccept = 1'b0;
    if (seq_reg == flash_ctl_pkg::SEQ_BUSY)
    begin
      if (!busy && !busyDly_reg)
        seq_next = flash_ctl_pkg::SEQ_IDLE;
    end
    else if (req.wr && !armed_reg)
      seq_next = flash_ctl_pkg::SEQ_IDLE;
    else if (req.wr && tooSoon)
      seq_next = flash_ctl_pkg::SEQ_IDLE;
    else if (req.wr)
    begin
      cmdAccept = 1'b1;
      case (seq_reg)
        flash_ctl_pkg::SEQ_IDLE:
          if (req.addr == `UNLOCK_A && req.data == `CMD_UNLOCK_A)
            seq_next = flash_ctl_pkg::SEQ_UNLOCK1;
        flash_ctl_pkg::SEQ_UNLOCK1:
          seq_next = (req.addr == `UNLOCK_B && req.data == `CMD_UNLOCK_B) ?
            flash_ctl_pkg::SEQ_UNLOCK2 : flash_ctl_pkg::SEQ_IDLE;
        flash_ctl_pkg::SEQ_UNLOCK2:
          if (req.addr == `UNLOCK_A && req.data == `CMD_ERASE)
            seq_next = flash_ctl_pkg::SEQ_CMD;
          else if (req.addr == `UNLOCK_A && req.data == `CMD_PROGRAM)
            seq_next = flash_ctl_pkg::SEQ_TARGET;
          else
            seq_next = flash_ctl_pkg::SEQ_IDLE;
        flash_ctl_pkg::SEQ_CMD:
          seq_next = (req.addr == `UNLOCK_A && req.data == `CMD_UNLOCK_A) ?
            flash_ctl_pkg::SEQ_UNLOCK4 : flash_ctl_pkg::SEQ_IDLE;
        flash_ctl_pkg::SEQ_UNLOCK4:
          seq_next = (req.addr == `UNLOCK_B && req.data == `CMD_UNLOCK_B) ?
            flash_ctl_pkg::SEQ_UNLOCK5 : flash_ctl_pkg::SEQ_IDLE;
        flash_ctl_pkg::SEQ_UNLOCK5:
          if (req.data == `CMD_SECTOR)
          begin
            seq_next = flash_ctl_pkg::SEQ_BUSY;
            startOp = 1'b1;
          end
          else
            seq_next = flash_ctl_pkg::SEQ_IDLE;
        flash_ctl_pkg::SEQ_TARGET:
        begin
          seq_next = flash_ctl_pkg::SEQ_BUSY;
          startOp = 1'b1;
        end
        default:
          seq_next = flash_ctl_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Sequence state and operation kind
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_reg <= flash_ctl_pkg::SEQ_IDLE;
      isErase_reg <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_next;
      if (startOp)
        isErase_reg <= (seq_reg == flash_ctl_pkg::SEQ_UNLOCK5);
    end
  end

  assign rejectEvt = req.wr && (seq_reg != flash_ctl_pkg::SEQ_BUSY) && !cmdAccept;

  // Array launch pulses and target latch
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arrayErase <= 1'b0;
      arrayProgram <= 1'b0;
      arrayAddr <= 16'h0000;
      arrayData <= 8'h00;
    end
    else
    begin
      arrayErase <= startOp && (seq_reg == flash_ctl_pkg::SEQ_UNLOCK5);
      arrayProgram <= startOp && (seq_reg == flash_ctl_pkg::SEQ_TARGET);
      if (startOp)
      begin
        arrayAddr <= req.addr;
        arrayData <= req.data;
      end
    end
  end

  // Busy duration depends on operation kind
  busy_timer u_busy (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(startOp),
    .count((seq_reg == flash_ctl_pkg::SEQ_UNLOCK5) ? 8'(`ERASE_CYCLES) : 8'(`PROGRAM_CYCLES)),
    .busy(busy)
  );

  // Delay covers the load cycle so busy never glitches low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busyDly_reg <= 1'b0;
    else
      busyDly_reg <= startOp;
  end

  assign doneEvt = (seq_reg == flash_ctl_pkg::SEQ_BUSY) && !busy && !busyDly_reg;

  // Toggle bit flips on every read during busy
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      toggle_reg <= 1'b0;
    else if (req.rd && seq_reg == flash_ctl_pkg::SEQ_BUSY)
      toggle_reg <= ~toggle_reg;
  end

  // Read data: while busy, bit 6 toggles; otherwise array contents
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      memRdata_reg <= 8'h00;
    else if (req.rd)
      memRdata_reg <= (seq_reg == flash_ctl_pkg::SEQ_BUSY) ?
        {1'b0, toggle_reg, 6'h00} : arrayRdata;
  end

  assign memRdata = memRdata_reg;

  // Nonmaskable event waits for the operation to end, then resets
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      nmiPending_reg <= 1'b0;
    else if (nmiEvent)
      nmiPending_reg <= 1'b1;
    else if (rstPulse_reg)
      nmiPending_reg <= 1'b0;
  end

  // Reset pulse from software code or a pending trap
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPulse_reg <= 1'b0;
    else
      rstPulse_reg <= (wrRstCtl && regWdata == `CODE_SYS_RESET) ||
        (nmiPending_reg && seq_reg != flash_ctl_pkg::SEQ_BUSY && !rstPulse_reg);
  end

  assign sysClkReset = rstPulse_reg;

  // Interrupt status: done, trap and rejected command
  assign irqSet = {rejectEvt, nmiEvent, doneEvt};
  assign irqClr = wrIrqStat ? regWdata[2:0] : 3'h0;

  for (genvar i = 0; i < 3; i++)
  begin : g_irq
    sticky_bit u_bit (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set(irqSet[i]),
      .clr(irqClr[i]),
      .q(irqStat[i])
    );
  end

  // Interrupt mask
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqMask_reg <= 3'h0;
    else if (wrIrqMask)
      irqMask_reg <= regWdata[2:0];
  end

  assign irq = |(irqStat & irqMask_reg);

  // Register read mux, answered next cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata_reg <= 8'h00;
    else if (regRd)
    begin
      if (regAddr == `ADDR_SYS_MAP_CONTROL)
        regRdata_reg <= mapCtl_reg;
      else if (regAddr == `ADDR_FLASH_CTRL_PRIMARY)
        regRdata_reg <= primary_reg;
      else if (regAddr == `ADDR_FLASH_STATUS)
        regRdata_reg <= {4'h0, armed_reg, busy, map_reg.vecRam, map_reg.ramCode};
      else if (regAddr == `ADDR_IRQ_STATUS)
        regRdata_reg <= {5'h00, irqStat};
      else if (regAddr == `ADDR_IRQ_MASK)
        regRdata_reg <= {5'h00, irqMask_reg};
      else
        regRdata_reg <= 8'h00;
    end
  end

  assign regRdata = regRdata_reg;
endmodule
`default_nettype wire

/* File: hdl/sticky_bit.sv */
// One sticky status bit, set wins over a write-one clear
`timescale 1ns/10ps
`default_nettype none
module sticky_bit (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic set, // Event pulse
  input wire logic clr, // Write-one clear
  output logic q // Sticky flag
);
  // Set has priority so an event in the clear cycle survives
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= 1'b0;
    else if (set)
      q <= 1'b1;
    else if (clr)
      q <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: pkg/flash_ctl_pkg.sv */
// Types shared by the flash control block
`default_nettype none
package flash_ctl_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_UNLOCK1 = 3'b001,
    SEQ_UNLOCK2 = 3'b010,
    SEQ_CMD = 3'b011,
    SEQ_UNLOCK4 = 3'b100,
    SEQ_UNLOCK5 = 3'b101,
    SEQ_TARGET = 3'b110,
    SEQ_BUSY = 3'b111
  } seq_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } bus_req_t;
  typedef struct packed {
    logic ramCode;
    logic vecRam;
  } map_state_t;
endpackage
`default_nettype wire

/* File: pkg/flash_ctl_regs.svh */
// Register addresses, field positions, key codes and timing counts for the flash control block
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH
// Register byte addresses on the plain port
`define ADDR_SYS_MAP_CONTROL 16'h0fc0
`define ADDR_SYS_MAP_KEY 16'h0fc1
`define ADDR_SYS_RESET_CONTROL 16'h0fc2
`define ADDR_FLASH_CTRL_PRIMARY 16'h0fd0
`define ADDR_FLASH_CTRL_CONFIRM 16'h0fd1
`define ADDR_FLASH_STATUS 16'h0fd2
`define ADDR_IRQ_STATUS 16'h0fd4
`define ADDR_IRQ_MASK 16'h0fd5
// Field positions
`define MAP_RAM_BIT 1
`define MAP_VEC_BIT 2
`define PRI_MODE_HI 7
`define PRI_MODE_LO 5
`define PRI_BOOT_BIT 4
`define PRI_AREA_HI 3
`define PRI_AREA_LO 2
`define PRI_ROM_BANK_SELECT_BIT 1
// Keys and codes
`define KEY_MAP 8'hd4
`define KEY_CONFIRM 8'hd5
`define CODE_SYS_RESET 8'h10
`define MODE_ARM 3'h5
`define MODE_DISARM 3'h2
`define AREA_DEFAULT 2'h0
// Reset values
`define RST_PRIMARY 8'h40
`define RST_MAP 8'h00
// Flash window and unlock addresses
`define FLASH_BASE 16'h8000
`define UNLOCK_A 16'hf555
`define UNLOCK_B 16'hfaaa
`define CMD_UNLOCK_A 8'haa
`define CMD_UNLOCK_B 8'h55
`define CMD_ERASE 8'h80
`define CMD_SECTOR 8'h30
`define CMD_PROGRAM 8'ha0
// Timing: machine cycle of 4 system clocks, busy times in ns
`define MC_CLKS 4
`define CLK_PERIOD_NS 40
`define MIN_CMD_SPACING_MC 3
`define ERASE_TIME_NS 4000
`define PROGRAM_TIME_NS 1000
`define ERASE_CYCLES (`ERASE_TIME_NS / `CLK_PERIOD_NS)
`define PROGRAM_CYCLES (`PROGRAM_TIME_NS / `CLK_PERIOD_NS)
`define MIN_CMD_CYCLES (`MIN_CMD_SPACING_MC * `MC_CLKS)
// Interrupt status bits
`define IRQ_DONE_BIT 0
`define IRQ_NMI_BIT 1
`define IRQ_REJECT_BIT 2
`endif

/* File: sim/flash_array_model.sv */
// Behavioural flash array on the far side of the control block
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  input wire logic sys_clk, // System clock
  input wire logic [15:0] memAddr, // Read address
  input wire logic arrayErase, // Erase pulse
  input wire logic arrayProgram, // Program pulse
  input wire logic [15:0] arrayAddr, // Target address
  input wire logic [7:0] arrayData, // Program data
  output logic [7:0] arrayRdata // Cell contents
);
  logic [7:0] cells [64];
  // Cells start dirty so a skipped erase shows up
  initial foreach (cells[i]) cells[i] = 8'h0f;
  // Erase sets ones; program only clears bits, like real cells
  always @(posedge sys_clk)
  begin
    if (arrayErase)
      foreach (cells[i]) cells[i] <= 8'hff;
    if (arrayProgram)
      cells[arrayAddr[5:0]] <= cells[arrayAddr[5:0]] & arrayData;
  end
  assign arrayRdata = cells[memAddr[5:0]];
endmodule
`default_nettype wire

/* File: sim/flash_erase_program_control_checker.sv */
// Port checks for the flash control block
`timescale 1ns/10ps
`default_nettype none
module flash_erase_program_control_checker (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [15:0] regAddr, // Reg address
  input wire logic [7:0] regWdata, // Reg data
  input wire logic regWr, // Reg write
  input wire logic memWr, // Flash write
  input wire logic memRd, // Flash read
  input wire logic [15:0] memAddr, // Flash address
  input wire logic [7:0] memWdata, // Flash data
  input wire logic [7:0] memRdata, // Read data
  input wire logic arrayErase, // Erase pulse
  input wire logic arrayProgram, // Program pulse
  input wire logic [15:0] arrayAddr, // Target
  input wire logic [7:0] arrayData, // Target data
  input wire logic ramCodeMap, // RAM map
  input wire logic vecRelocate, // Vectors in RAM
  input wire logic [1:0] flashArea, // Area
  input wire logic romBankSelect, // ROM select
  input wire logic sysClkReset // Clock reset
);
  logic [7:0] priW;
  logic [7:0] mapW;
  logic [7:0] busyCnt;
  logic keyMap;
  logic keyOk;
  assign keyMap = regWr && regAddr == 16'h0fc1;
  assign keyOk = regWr && regAddr == 16'h0fd1 && regWdata == 8'hd5;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadows of the pending settings, applied only on a key
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      priW <= 8'h40;
      mapW <= 8'h00;
    end
    else if (regWr && regAddr == 16'h0fd0)
      priW <= regWdata;
    else if (regWr && regAddr == 16'h0fc0)
      mapW <= regWdata;
  // Rough busy window; margin kept at both ends
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      busyCnt <= 8'h00;
    else if (arrayErase)
      busyCnt <= 8'h64;
    else if (arrayProgram)
      busyCnt <= 8'h19;
    else if (busyCnt != 8'h00)
      busyCnt <= busyCnt - 8'h01;
  a_map_apply: assert property (keyMap && regWdata == 8'hd4 |=>
    ramCodeMap == mapW[1] && vecRelocate == mapW[2]) else $error("map not applied");
  a_key_ignored: assert property (keyMap && regWdata != 8'hd4 |=>
    $stable(ramCodeMap) && $stable(vecRelocate)) else $error("bad key took effect");
  a_arm_apply: assert property (keyOk && priW[7:5] == 3'h5 |=>
    flashArea == priW[3:2] && romBankSelect == priW[1]) else $error("arm not applied");
  a_disarm_area: assert property (keyOk && priW[7:5] == 3'h2 && priW[3:2] == 2'h0
    |=> flashArea == 2'h0) else $error("area not restored");
  a_erase_cmd: assert property (arrayErase |-> $past(memWr) &&
    $past(memWdata) == 8'h30) else $error("erase without final write");
  a_prog_latch: assert property (arrayProgram |-> $past(memWr) &&
    arrayAddr == $past(memAddr) && arrayData == $past(memWdata)) else $error("bad program");
  a_pulse_one: assert property (arrayErase || arrayProgram |=>
    !arrayErase && !arrayProgram) else $error("array pulse too long");
  a_toggle_read: assert property (busyCnt > 8'h02 && memRd ##1 memRd |=>
    memRdata != $past(memRdata)) else $error("no toggle while busy");
  a_reset_code: assert property (regWr && regAddr == 16'h0fc2 && regWdata == 8'h10
    |-> ##[1:2] sysClkReset) else $error("no clock reset");
  a_reset_single: assert property (sysClkReset |=> !sysClkReset) else $error("reset pulse long");
  a_nmi_wait: assert property (sysClkReset |-> busyCnt < 8'h02) else $error("reset while busy");
  c_erase: cover property (arrayErase);
  c_program: cover property (arrayProgram);
  c_reset: cover property (sysClkReset);
endmodule
bind flash_erase_program_control flash_erase_program_control_checker chk_inst (.sys_clk, .rst_n,
  .regAddr, .regWdata, .regWr, .memWr, .memRd, .memAddr, .memWdata, .memRdata, .arrayErase,
  .arrayProgram, .arrayAddr, .arrayData, .ramCodeMap, .vecRelocate, .flashArea,
  .romBankSelect, .sysClkReset);
`default_nettype wire

/* File: sim/flash_erase_program_control_tb.sv */
// Self-checking bench for the flash control block
`timescale 1ns/10ps
`default_nettype none
module flash_erase_program_control_tb;
  logic sys_clk, rst_n, regWr, regRd, memWr, memRd, nmiEvent, arrayErase, arrayProgram;
  logic ramCodeMap, vecRelocate, romBankSelect, bootRomArea, sysClkReset, irq;
  logic [15:0] regAddr, memAddr, arrayAddr;
  logic [7:0] regWdata, memWdata, regRdata, memRdata, arrayRdata, arrayData, v;
  logic [1:0] flashArea;
  logic tog;
  int errors, checks_done, nEr, nPr, nRs;
  typedef struct packed {
    logic [15:0] wa; logic [7:0] wd; logic [15:0] ra; logic [7:0] ex; logic [1:0] ar;
  } row_t;
  // Write, then read back status or register, with applied area
  row_t rows [11] = '{'{16'h0fc0, 8'h06, 16'h0fd2, 8'h00, 2'h0},
    '{16'h0fc1, 8'h55, 16'h0fd2, 8'h00, 2'h0}, '{16'h0fc1, 8'hd4, 16'h0fd2, 8'h03, 2'h0},
    '{16'h0fd0, 8'ha6, 16'h0fd2, 8'h03, 2'h0}, '{16'h0fd1, 8'hd5, 16'h0fd2, 8'h0b, 2'h1},
    '{16'h0fd0, 8'h40, 16'h0fd2, 8'h0b, 2'h1}, '{16'h0fd1, 8'hd5, 16'h0fd2, 8'h03, 2'h0},
    '{16'h0fc0, 8'h00, 16'h0fd2, 8'h03, 2'h0}, '{16'h0fc1, 8'hd4, 16'h0fd2, 8'h00, 2'h0},
    '{16'h0fe0, 8'hff, 16'h0fe0, 8'h00, 2'h0}, '{16'h0fd5, 8'h07, 16'h0fd5, 8'h07, 2'h0}};
  flash_erase_program_control flash_erase_program_control_inst (.sys_clk, .rst_n, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .memAddr, .memWdata, .memWr, .memRd, .arrayRdata,
    .memRdata, .arrayErase, .arrayProgram, .arrayAddr, .arrayData, .nmiEvent, .ramCodeMap,
    .vecRelocate, .flashArea, .romBankSelect, .bootRomArea, .sysClkReset, .irq);
  flash_array_model flash_array_model_inst (.sys_clk, .memAddr, .arrayErase, .arrayProgram,
    .arrayAddr, .arrayData, .arrayRdata);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Pulse counters, so no pulse slips between task calls
  always @(posedge sys_clk)
  begin
    nEr <= nEr + int'(arrayErase);
    nPr <= nPr + int'(arrayProgram);
    nRs <= nRs + int'(sysClkReset);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("counts: %0d checks, %0d errors", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // Gap of 10 idle clocks gives the 12 clock write spacing
  task automatic mw(input logic [15:0] a, input logic [7:0] d, input int gap);
    @(posedge sys_clk);
    memAddr <= a;
    memWdata <= d;
    memWr <= 1'b1;
    @(posedge sys_clk);
    memWr <= 1'b0;
    repeat (gap) @(posedge sys_clk);
  endtask
  task automatic unlock(input logic [7:0] c);
    mw(16'hf555, 8'haa, 10);
    mw(16'hfaaa, 8'h55, 10);
    mw(16'hf555, c, 10);
  endtask
  // Back-to-back read pairs until equal; tog marks a first differing pair
  task automatic poll(input logic [15:0] a);
    logic [7:0] d1;
    tog = 1'b0;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge sys_clk);
      memAddr <= a;
      memRd <= 1'b1;
      @(posedge sys_clk);
      #1 d1 = memRdata;
      @(posedge sys_clk);
      memRd <= 1'b0;
      #1 v = memRdata;
      if (v === d1)
        return;
      if (i == 0)
        tog = 1'b1;
    end
    errors++;
    close_out();
  endtask
  initial
  begin
    #400000;
    errors++;
    close_out();
  end
  initial
  begin
    {rst_n, regWr, regRd, memWr, memRd, nmiEvent} = 6'h00;
    {regAddr, memAddr, regWdata, memWdata} = 48'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].ex);
      chk({6'h0, flashArea}, {6'h0, rows[i].ar});
    end
    $display("test table done");
    mw(16'hf555, 8'haa, 10);
    rd(16'h0fd4, 8'h04);
    chk({7'h0, irq}, 8'h01);
    wr(16'h0fd5, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(16'h0fd5, 8'h07);
    wr(16'h0fd4, 8'h04);
    rd(16'h0fd4, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test unarmed done");
    // Map, arm area 01, then a sequence with writes only two clocks apart
    wr(16'h0fc0, 8'h06);
    wr(16'h0fc1, 8'hd4);
    wr(16'h0fd0, 8'ha4);
    wr(16'h0fd1, 8'hd5);
    mw(16'hf555, 8'haa, 0);
    mw(16'hfaaa, 8'h55, 10);
    rd(16'h0fd4, 8'h04);
    wr(16'h0fd4, 8'h04);
    unlock(8'h80);
    mw(16'hf555, 8'haa, 10);
    mw(16'hfaaa, 8'h55, 10);
    mw(16'h8010, 8'h30, 10);
    chk(8'(nEr), 8'h01);
    poll(16'h8010);
    chk({7'h0, tog}, 8'h01);
    chk(v, 8'hff);
    rd(16'h0fd4, 8'h01);
    wr(16'h0fd4, 8'h01);
    $display("test erase done");
    // Program with a nonmaskable event landing mid-busy
    unlock(8'ha0);
    // Poll no sooner than three machine cycles after the last write
    mw(16'h8010, 8'h3c, 10);
    nmiEvent <= 1'b1;
    @(posedge sys_clk);
    nmiEvent <= 1'b0;
    chk(8'(nPr), 8'h01);
    chk(8'(nRs), 8'h00);
    poll(16'h8010);
    chk({7'h0, tog}, 8'h01);
    chk(v, 8'h3c);
    repeat (3) @(posedge sys_clk);
    chk(8'(nRs), 8'h01);
    rd(16'h0fd4, 8'h03);
    $display("test program done");
    // Disarm with boot area set, so the boot output is seen to move
    wr(16'h0fd0, 8'h50);
    wr(16'h0fd1, 8'hd5);
    chk({5'h0, bootRomArea, flashArea}, 8'h04);
    wr(16'h0fd4, 8'h03);
    mw(16'hf555, 8'haa, 10);
    rd(16'h0fd4, 8'h04);
    chk(8'(nPr), 8'h01);
    wr(16'h0fc2, 8'h10);
    repeat (2) @(posedge sys_clk);
    chk(8'(nRs), 8'h02);
    $display("test disarm done");
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(16'h0fd0, 8'h40);
    rd(16'h0fd2, 8'h00);
    chk({6'h0, irq, ramCodeMap}, 8'h00);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
